/* File: chip_id_and_startup_control_tb.sv */
`timescale 1ns/10ps
module chip_id_and_startup_control_tb
  import chip_id_pkg::*;
;
  logic         ref_clk, rst_b, strap_h, strap_l, rmii; // Clock, reset, pins
  reg_req_type  reg_req;                      // Register strobe port
  logic [7:0]   rd_data, ee_addr, ee_data;    // Read data, EEPROM bus
  logic         run, ee_req, ee_valid, ee_nack, done; // Status and handshake
  logic [1:0]   ee_mode;                      // Far-side behaviour
  cfg_load_type cfg_load;                     // Loaded bytes
  int           err_total, checked, load_cnt; // Tallies

  // Revision keeps its default; a short image keeps the load phase brief
  chip_id_startup #(.FAMILY_CODE(8'hA5), .ID_NIBBLE_MII(4'h3), .ID_NIBBLE_RMII(4'h5),
    .EE_LAST_ADDR(8'h04)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .mode_strap_high(strap_h), .mode_strap_low(strap_l), .port4_rmii_mode(rmii),
    .reg_req(reg_req), .reg_rd_data_q(rd_data), .switch_run_q(run),
    .eeprom_rd_req_q(ee_req), .eeprom_rd_addr_q(ee_addr), .eeprom_rd_valid(ee_valid),
    .eeprom_rd_data(ee_data), .eeprom_rd_nack(ee_nack), .cfg_load_q(cfg_load),
    .startup_done_q(done));
  // Model's default family byte matches the device's family code
  eeprom_model u_ee (.ref_clk(ref_clk), .rst_b(rst_b), .ee_mode(ee_mode),
    .rd_req(ee_req), .rd_addr(ee_addr), .rd_valid(ee_valid), .rd_nack(ee_nack),
    .rd_data(ee_data));

  always #2 ref_clk = ~ref_clk; // 250 MHz

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Every loaded byte must arrive in ascending order with the stored value
  // Looked at mid-cycle, where the one-cycle strobe has settled
  always @(negedge ref_clk) begin
    if (cfg_load.valid === 1'b1) begin
      check(cfg_load.addr, 8'(load_cnt + 2));
      check(cfg_load.data, 8'(load_cnt + 2) ^ 8'h3C);
      load_cnt++;
    end
  end

  // Strobes rise just after an edge and drop after the taking edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    #1 reg_req.wr = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    #1 reg_req.rd = 1'b0;
    check(rd_data, exp);
  endtask

  // Straps only ever (0,0), (1,0) or (0,1); the test pair is never used
  task automatic restart(input logic h, input logic l, input logic [1:0] m);
    int n;
    @(posedge ref_clk);
    #1 rst_b = 1'b0;
    strap_h = h;
    strap_l = l;
    ee_mode = m;
    repeat (20) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    load_cnt = 0;
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check(8'(done), 8'h01);
  endtask

  task automatic t_ident;
    restart(1'b1, 1'b0, 2'h0);
    reg_rd(8'h00, 8'hA5);
    reg_wr(8'h00, 8'h5A);
    reg_rd(8'h00, 8'hA5);
    reg_rd(8'h01, 8'h32);
    reg_wr(8'h01, 8'hFE);
    reg_rd(8'h01, 8'h32);
    rmii = 1'b1;
    repeat (6) @(posedge ref_clk);
    reg_rd(8'h01, 8'h52);
    rmii = 1'b0;
    reg_rd(8'h02, 8'h00);
    $display("Test ident done");
  endtask

  task automatic t_manual;
    restart(1'b1, 1'b0, 2'h1);
    check(8'(run), 8'h00);
    check(8'(load_cnt), 8'h00);
    reg_wr(8'h01, 8'h01);
    check(8'(run), 8'h01);
    reg_rd(8'h01, 8'h33);
    reg_wr(8'h01, 8'h00);
    check(8'(run), 8'h00);
    restart(1'b0, 1'b1, 2'h1);
    check(8'(run), 8'h00);
    $display("Test manual done");
  endtask

  task automatic t_auto_good;
    restart(1'b0, 1'b0, 2'h1);
    check(8'(load_cnt), 8'h03);
    check(8'(run), 8'h01);
    reg_wr(8'h01, 8'h00);
    check(8'(run), 8'h00);
    $display("Test auto good done");
  endtask

  task automatic t_auto_none;
    restart(1'b0, 1'b0, 2'h0);
    check(8'(load_cnt), 8'h00);
    check(8'(run), 8'h01);
    $display("Test auto absent done");
  endtask

  task automatic t_auto_bad;
    for (int m = 2; m < 4; m++) begin
      restart(1'b0, 1'b0, 2'(m));
      check(8'(load_cnt), 8'h00);
      check(8'(run), 8'h01);
    end
    $display("Test auto bad image done");
  endtask

  task automatic close_out;
    $display("Counts: checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Seven restarts of under a hundred cycles each fit well inside this span
  initial begin
    #80000;
    err_total++;
    close_out();
  end

  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    strap_h = 1'b1;
    strap_l = 1'b0;
    rmii = 1'b0;
    ee_mode = 2'h0;
    reg_req = '0;
    err_total = 0;
    checked = 0;
    load_cnt = 0;
    t_ident();
    t_manual();
    t_auto_good();
    t_auto_none();
    t_auto_bad();
    close_out();
  end
endmodule

/* File: chip_id_pkg.sv */
package chip_id_pkg;

  // Register offsets
  localparam logic [7:0] CHIP_FAMILY_CODE_OFS = 8'h00;
  localparam logic [7:0] REV_RUN_CTRL_OFS     = 8'h01;

  // Field positions inside revision_and_run_control
  localparam int ID_NIBBLE_MSB = 7;
  localparam int ID_NIBBLE_LSB = 4;
  localparam int REV_FIELD_MSB = 3;
  localparam int REV_FIELD_LSB = 1;
  localparam int RUN_BIT_POS   = 0;

  // Values after reset
  localparam logic       RUN_RESET_VAL  = 1'b0;
  localparam logic [7:0] RD_DATA_RESET  = 8'h00;

  // EEPROM image layout: byte 0 family, byte 1 revision, rest register contents
  localparam logic [7:0] EE_FAMILY_ADDR = 8'h00;
  localparam logic [7:0] EE_REV_ADDR    = 8'h01;
  localparam logic [7:0] EE_LOAD_FIRST  = 8'h02;
  localparam logic [3:0] EE_REV_UPPER_OK = 4'h0;

  // Cycles that straps must settle after reset release
  localparam logic [3:0] STRAP_SETTLE_CYC = 4'h8;

  // Start-up mode from {mode_strap_high, mode_strap_low}
  localparam logic [1:0] STRAP_AUTO   = 2'b00;
  localparam logic [1:0] STRAP_MANUAL = 2'b10;
  localparam logic [1:0] STRAP_HOLD   = 2'b01;
  localparam logic [1:0] STRAP_TEST   = 2'b11;

  // Register access request from the serial management front end
  typedef struct packed {
    logic       wr;    // Write strobe, one cycle
    logic       rd;    // Read strobe, one cycle
    logic [7:0] addr;  // Eight-bit register address
    logic [7:0] wdata; // Write data
  } reg_req_type;

  // Byte handed to the rest of the register map while loading
  typedef struct packed {
    logic       valid; // One-cycle strobe
    logic [7:0] addr;  // Target register address
    logic [7:0] data;  // Value from EEPROM
  } cfg_load_type;

  // Start-up sequencer states
  typedef enum logic [2:0] {
    st_strap, st_rd_id, st_rd_rev, st_load, st_start, st_idle
  } boot_state_type;

endpackage

/* File: chip_id_startup.sv */
`timescale 1ns/10ps
// Contract
// - Family code at 0x00, read-only
// - Bits 7-4 of 0x01 reflect port-4 RMII
// - Revision in bits 3-1, run bit 0
// - Strap (1,0): start only on host write
// - Writing zero to run bit halts switching, except in the st_start cycle, where the auto start wins
// - Strap (0,0): auto start after EEPROM attempt
// - No EEPROM: keep all built-in defaults
// - Check byte0 equals family, byte1 upper zero
// - Valid EEPROM contents override register defaults
// - Straps (1,0) or (0,1): no auto start
module chip_id_startup
  import chip_id_pkg::*;
#(
  parameter logic [7:0] FAMILY_CODE  = 8'hA5, // Arbitrary value
  parameter logic [3:0] ID_NIBBLE_MII  = 4'h3, // Arbitrary value
  parameter logic [3:0] ID_NIBBLE_RMII = 4'h5, // Arbitrary value
  parameter logic [2:0] REVISION     = 3'h1, // Arbitrary value
  parameter logic [7:0] EE_LAST_ADDR = 8'hFF  // Last EEPROM byte loaded
) (
  input  wire logic         ref_clk,          // System clock, 250 MHz
  input  wire logic         rst_b,            // Async reset, active low
  input  wire logic         mode_strap_high,  // Start-up strap, pin
  input  wire logic         mode_strap_low,   // Start-up strap, pin
  input  wire logic         port4_rmii_mode,  // Port 4 in RMII, pin
  input  wire reg_req_type  reg_req,          // Register access from front end
  output logic [7:0]        reg_rd_data_q,    // Read data, one cycle after rd
  output logic              switch_run_q,     // Switching function enabled
  output logic              eeprom_rd_req_q,  // Byte read request, pulse
  output logic [7:0]        eeprom_rd_addr_q, // Byte address of request
  input  wire logic         eeprom_rd_valid,  // Byte returned
  input  wire logic [7:0]   eeprom_rd_data,   // Returned byte
  input  wire logic         eeprom_rd_nack,   // No EEPROM answered
  output cfg_load_type      cfg_load_q,       // Loaded byte to register map
  output logic              startup_done_q    // Sequencer finished
);

  logic [2:0]     hi_sync_q;     // Strap high synchroniser
  logic [2:0]     lo_sync_q;     // Strap low synchroniser
  logic [2:0]     rmii_sync_q;   // RMII pin synchroniser
  logic           rmii_q;        // Filtered RMII level
  logic [3:0]     settle_q;      // Strap settle counter
  logic [1:0]     mode_q;        // Captured strap mode
  boot_state_type state_q;       // Sequencer state
  logic           host_wr_run;   // Host write to the run register

  assign host_wr_run = reg_req.wr && (reg_req.addr == REV_RUN_CTRL_OFS);

  // Three-stage synchronisers; only stages two and three are compared
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_sync_q   <= 3'h0;
      lo_sync_q   <= 3'h0;
      rmii_sync_q <= 3'h0;
    end else begin
      hi_sync_q   <= {hi_sync_q[1:0], mode_strap_high};
      lo_sync_q   <= {lo_sync_q[1:0], mode_strap_low};
      rmii_sync_q <= {rmii_sync_q[1:0], port4_rmii_mode};
    end
  end

  // RMII level changes only once two stages agree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rmii_q <= 1'b0;
    end else if (rmii_sync_q[1] == rmii_sync_q[2]) begin
      rmii_q <= rmii_sync_q[2];
    end
  end

  // Settle counter: straps are sampled after the pins had time to charge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_q <= 4'h0;
    end else if (settle_q != STRAP_SETTLE_CYC) begin
      settle_q <= settle_q + 4'h1;
    end
  end

  // Start-up sequencer and EEPROM request generation
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q          <= st_strap;
      mode_q           <= STRAP_MANUAL;
      eeprom_rd_req_q  <= 1'b0;
      eeprom_rd_addr_q <= EE_FAMILY_ADDR;
      cfg_load_q       <= '0;
      startup_done_q   <= 1'b0;
    end else begin
      eeprom_rd_req_q  <= 1'b0;
      cfg_load_q.valid <= 1'b0;
      case (state_q)
        st_strap: begin
          // Wait for settle and stable straps before committing to a mode
          if (settle_q == STRAP_SETTLE_CYC && hi_sync_q[1] == hi_sync_q[2]
              && lo_sync_q[1] == lo_sync_q[2]) begin
            mode_q <= {hi_sync_q[2], lo_sync_q[2]};
            if ({hi_sync_q[2], lo_sync_q[2]} == STRAP_AUTO) begin
              state_q          <= st_rd_id;
              eeprom_rd_req_q  <= 1'b1;
              eeprom_rd_addr_q <= EE_FAMILY_ADDR;
            end else begin
              state_q        <= st_idle;
              startup_done_q <= 1'b1;
            end
          end
        end
        st_rd_id: begin
          if (eeprom_rd_nack) begin
            state_q <= st_start;
          end else if (eeprom_rd_valid) begin
            if (eeprom_rd_data == FAMILY_CODE) begin
              state_q          <= st_rd_rev;
              eeprom_rd_req_q  <= 1'b1;
              eeprom_rd_addr_q <= EE_REV_ADDR;
            end else begin
              state_q <= st_start;
            end
          end
        end
        st_rd_rev: begin
          if (eeprom_rd_nack) begin
            state_q <= st_start;
          end else if (eeprom_rd_valid) begin
            if (eeprom_rd_data[7:4] == EE_REV_UPPER_OK) begin
              state_q          <= st_load;
              eeprom_rd_req_q  <= 1'b1;
              eeprom_rd_addr_q <= EE_LOAD_FIRST;
            end else begin
              state_q <= st_start;
            end
          end
        end
        st_load: begin
          // One byte in flight; each returned byte overrides a default
          if (eeprom_rd_nack) begin
            state_q <= st_start;
          end else if (eeprom_rd_valid) begin
            cfg_load_q.valid <= 1'b1;
            cfg_load_q.addr  <= eeprom_rd_addr_q;
            cfg_load_q.data  <= eeprom_rd_data;
            if (eeprom_rd_addr_q == EE_LAST_ADDR) begin
              state_q <= st_start;
            end else begin
              eeprom_rd_req_q  <= 1'b1;
              eeprom_rd_addr_q <= eeprom_rd_addr_q + 8'h01;
            end
          end
        end
        st_start: begin
          state_q        <= st_idle;
          startup_done_q <= 1'b1;
        end
        st_idle: begin
          state_q <= st_idle;                // Host owns the run bit now
        end
        default: begin
          state_q <= st_strap;
        end
      endcase
    end
  end

  // Run control: automatic start wins over a same-cycle host clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      switch_run_q <= RUN_RESET_VAL;
    end else if (state_q == st_start) begin
      switch_run_q <= 1'b1;
    end else if (host_wr_run) begin
      switch_run_q <= reg_req.wdata[RUN_BIT_POS];
    end
  end

  // Register read path; writes to read-only fields are simply dropped
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rd_data_q <= RD_DATA_RESET;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        CHIP_FAMILY_CODE_OFS: reg_rd_data_q <= FAMILY_CODE;
        REV_RUN_CTRL_OFS: begin
          reg_rd_data_q <= {(rmii_q ? ID_NIBBLE_RMII : ID_NIBBLE_MII),
                            REVISION, switch_run_q};
        end
        default: reg_rd_data_q <= RD_DATA_RESET;
      endcase
    end
  end

  // Checks
  sequence s_id_ok;
    state_q == st_rd_id && eeprom_rd_valid && !eeprom_rd_nack
      && eeprom_rd_data == FAMILY_CODE;
  endsequence

  sequence s_rev_asked;
    state_q == st_rd_rev && eeprom_rd_req_q && eeprom_rd_addr_q == EE_REV_ADDR;
  endsequence

  property p_family_ro;
    @(posedge ref_clk) disable iff (!rst_b)
    reg_req.rd && reg_req.addr == CHIP_FAMILY_CODE_OFS |=> reg_rd_data_q == FAMILY_CODE;
  endproperty
  a_family_ro: assert property (p_family_ro) else $error("family code wrong");

  property p_id_nibble;
    @(posedge ref_clk) disable iff (!rst_b)
    reg_req.rd && reg_req.addr == REV_RUN_CTRL_OFS |=>
      reg_rd_data_q[7:4] == ($past(rmii_q) ? ID_NIBBLE_RMII : ID_NIBBLE_MII);
  endproperty
  a_id_nibble: assert property (p_id_nibble) else $error("id nibble wrong");

  property p_rev_run;
    @(posedge ref_clk) disable iff (!rst_b)
    reg_req.rd && reg_req.addr == REV_RUN_CTRL_OFS |=>
      reg_rd_data_q[3:1] == REVISION && reg_rd_data_q[0] == $past(switch_run_q);
  endproperty
  a_rev_run: assert property (p_rev_run) else $error("revision or run bit wrong");

  property p_manual_hold;
    @(posedge ref_clk) disable iff (!rst_b)
    state_q == st_idle && !switch_run_q && !host_wr_run |=> !switch_run_q;
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("started without host");

  property p_halt;
    @(posedge ref_clk) disable iff (!rst_b)
    host_wr_run && !reg_req.wdata[RUN_BIT_POS] && state_q != st_start |=> !switch_run_q;
  endproperty
  a_halt: assert property (p_halt) else $error("run bit did not clear");

  property p_auto_start;
    @(posedge ref_clk) disable iff (!rst_b)
    state_q == st_start |=> switch_run_q && state_q == st_idle && startup_done_q;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("auto start missed");

  property p_nack_keeps;
    @(posedge ref_clk) disable iff (!rst_b)
    (state_q == st_rd_id || state_q == st_rd_rev) && eeprom_rd_nack
      |=> state_q == st_start && !cfg_load_q.valid ##1 !cfg_load_q.valid;
  endproperty
  a_nack_keeps: assert property (p_nack_keeps) else $error("loaded without EEPROM");

  property p_id_check;
    @(posedge ref_clk) disable iff (!rst_b)
    s_id_ok |=> s_rev_asked;
  endproperty
  a_id_check: assert property (p_id_check) else $error("revision byte not read");

  property p_load;
    @(posedge ref_clk) disable iff (!rst_b)
    state_q == st_load && eeprom_rd_valid && !eeprom_rd_nack |=>
      cfg_load_q.valid && cfg_load_q.data == $past(eeprom_rd_data);
  endproperty
  a_load: assert property (p_load) else $error("EEPROM byte not loaded");

  property p_no_auto;
    @(posedge ref_clk) disable iff (!rst_b)
    state_q != st_strap && mode_q != STRAP_AUTO |-> state_q != st_start;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("auto start in manual mode");

  property p_bad_id;
    @(posedge ref_clk) disable iff (!rst_b)
    state_q == st_rd_id && eeprom_rd_valid && !eeprom_rd_nack
      && eeprom_rd_data != FAMILY_CODE |=> state_q == st_start ##1 switch_run_q;
  endproperty
  a_bad_id: assert property (p_bad_id) else $error("bad image not skipped");

endmodule

/* File: eeprom_model.sv */
`timescale 1ns/10ps
module eeprom_model
  import chip_id_pkg::*;
#(
  parameter logic [7:0] FAMILY = 8'hA5 // Arbitrary value, matches the device
) (
  input  wire logic       ref_clk,  // System clock
  input  wire logic       rst_b,    // Async reset, active low
  input  wire logic [1:0] ee_mode,  // 0 absent, 1 good, 2 bad family, 3 bad upper nibble
  input  wire logic       rd_req,   // Byte request pulse
  input  wire logic [7:0] rd_addr,  // Byte address
  output logic            rd_valid, // Byte returned
  output logic            rd_nack,  // Nobody answered
  output logic [7:0]      rd_data   // Returned byte
);
  logic [2:0] wait_q; // Latency count, slow on purpose
  logic [7:0] addr_q; // Address held while pending

  // One request at a time, answered three cycles late
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q   <= 3'h0;
      addr_q   <= 8'h00;
      rd_valid <= 1'b0;
      rd_nack  <= 1'b0;
      rd_data  <= 8'h00;
    end else begin
      rd_valid <= 1'b0;
      rd_nack  <= 1'b0;
      rd_data  <= ~rd_data; // Released bus flips each cycle, so the last byte shows again every other cycle
      if (rd_req) begin
        wait_q <= 3'h3;
        addr_q <= rd_addr;
      end else if (wait_q == 3'h1) begin
        wait_q   <= 3'h0;
        rd_nack  <= (ee_mode == 2'h0);
        rd_valid <= (ee_mode != 2'h0);
        case (addr_q)
          8'h00:   rd_data <= (ee_mode == 2'h2) ? ~FAMILY : FAMILY;
          8'h01:   rd_data <= (ee_mode == 2'h3) ? 8'h12 : 8'h02;
          default: rd_data <= addr_q ^ 8'h3C;
        endcase
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end
endmodule
